// >>> bench/testbench.sv
`timescale 1ns/1ps
`include "tsp_defs.vh"

// Self-checking bench for the placement checker and translator.
module testbench;
    reg CORE_CLK = 1'b0;
    reg SYS_RST = 1'b1;
    reg CLK_EN = 1'b1;
    reg [3:0] AVS_ADDRESS = 4'h0;
    reg AVS_READ = 1'b0;
    reg AVS_WRITE = 1'b0;
    reg [31:0] AVS_WRITEDATA = 32'h0;
    reg [3:0] AVS_BYTEENABLE = 4'hf;
    wire [31:0] AVS_READDATA, XL_ADDR, XL_OUT;
    wire AVS_WAITREQUEST, IRQ, XL_REQ, XL_HOST, XL_VALID, XL_TILED;
    wire [15:0] XL_X, XL_Y;
    integer error_cnt = 0;
    integer n_tests = 0;
    integer i, w;
    reg [31:0] rnd = 32'h8dcbaf2d;
    reg [31:0] off;
    logic [31:0] exp_rd[$];
    logic [32:0] exp_xl[$];
    reg [32:0] xe;
    localparam [31:0] FB = 32'h0010_0000;
    localparam [31:0] FP = 32'h0000_0400;

    // Free-running 25 MHz clock.
    initial forever #20 CORE_CLK = ~CORE_CLK;

    tsp_top #(.CRD_W(16)) i_tsp_top (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
        .XL_REQ(XL_REQ), .XL_HOST(XL_HOST), .XL_ADDR(XL_ADDR), .XL_X(XL_X), .XL_Y(XL_Y),
        .XL_VALID(XL_VALID), .XL_OUT(XL_OUT), .XL_TILED(XL_TILED));
    tsp_xl_model u_xl (.clk(CORE_CLK), .req(XL_REQ), .host(XL_HOST), .addr(XL_ADDR),
        .x(XL_X), .y(XL_Y));

    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Reference tiling: X tiles 512B by 8 rows, Y tiles 16B columns by 32 rows.
    function automatic [31:0] tl(input [1:0] wk, input [31:0] p, input [31:0] x,
        input [31:0] y);
        if (wk == `TSP_WALK_X) tl = ((y / 8) * (p / 512) + x / 512) * 4096 + (y % 8) * 512 + x % 512;
        else if (wk == `TSP_WALK_Y)
            tl = ((y / 32) * (p / 128) + x / 128) * 4096 + ((x % 128) / 16) * 512 + (y % 32) * 16 + x % 16;
        else tl = y * p + x;
    endfunction

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            error_cnt = error_cnt + 1;
        end
    endtask

    // Bus master: holds the request until waitrequest is sampled low at a rising edge.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        @(posedge CORE_CLK);
        AVS_ADDRESS <= a;
        AVS_READ <= !wr;
        AVS_WRITE <= wr;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        do begin
            @(posedge CORE_CLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask

    task automatic xl(input logic h, input logic [31:0] a, input logic [15:0] x,
        input logic [15:0] y, input logic t, input logic [31:0] e);
        exp_xl.push_back({t, e});
        rnd = lfsr(rnd);
        u_xl.send(h, a, x, y, rnd[0]);
    endtask

    // Programs a surface, triggers the checks and reads the live violation vector.
    task automatic chk(input logic [7:0] c, input logic [31:0] b, input logic [31:0] p,
        input logic [31:0] wd, input logic [4:0] v);
        wr(`TSP_REG_SURF_BASE, b);
        wr(`TSP_REG_SURF_PITCH, p);
        wr(`TSP_REG_SURF_WIDTH, wd);
        wr(`TSP_REG_SURF_CTRL, {24'h0, c});
        wr(`TSP_REG_CHECK, 32'h1);
        rd(`TSP_REG_CHECK, {27'h0, v});
    endtask

    task automatic irq_is(input logic e);
        @(negedge CORE_CLK);
        cmp("irq", {31'h0, e}, {31'h0, IRQ});
    endtask

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Scoreboard: each result at the ports takes the oldest expectation.
    // A frozen clock enable stretches the answer pulse, so it counts once, at the enabled edge.
    always @(posedge CORE_CLK) begin
        if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) cmp("readdata", exp_rd.pop_front(), AVS_READDATA);
        if (XL_VALID === 1'b1 && CLK_EN === 1'b1) begin
            xe = exp_xl.pop_front();
            cmp("xl_out", xe[31:0], XL_OUT);
            cmp("xl_tiled", {31'h0, xe[32]}, {31'h0, XL_TILED});
        end
    end

    // The whole sequence needs well under ten thousand cycles.
    initial begin
        repeat (30000) @(posedge CORE_CLK);
        error_cnt = error_cnt + 1;
        give_verdict;
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        for (i = 0; i < 16; i = i + 1) if (i != 7) rd(i[3:0], 32'h0);
        wr(4'hf, 32'hffff_ffff);
        rd(4'hf, 32'h0);
        bus(1'b1, `TSP_REG_SURF_PITCH, 32'hffff_ffff, 4'h2);
        rd(`TSP_REG_SURF_PITCH, 32'h0000_ff00);
        repeat (4) begin
            rnd = lfsr(rnd);
            xl(1'b1, rnd, 16'h0, 16'h0, 1'b0, rnd);
        end
        // X fence of two tiles per row, so rows of 8KB.
        wr(`TSP_REG_FENCE_BASE, FB);
        wr(`TSP_REG_FENCE_END, 32'h0020_0000);
        wr(`TSP_REG_FENCE_CTRL, 32'h0000_0203);
        xl(1'b1, FB, 16'h0, 16'h0, 1'b1, FB);
        xl(1'b1, FB + 8 * FP, 16'h0, 16'h0, 1'b1, FB + 32'h2000);
        xl(1'b1, FB + 32'h305, 16'h0, 16'h0, 1'b1, FB + 32'h1105);
        xl(1'b1, 32'h0020_0000, 16'h0, 16'h0, 1'b0, 32'h0020_0000);
        repeat (4) begin
            rnd = lfsr(rnd);
            off = {12'h0, rnd[19:0]};
            xl(1'b1, FB + off, 16'h0, 16'h0, 1'b1, FB + tl(2'h1, FP, off % FP, off / FP));
        end
        // Client surface over the fence: the fence must not apply.
        wr(`TSP_REG_SURF_BASE, FB);
        wr(`TSP_REG_SURF_PITCH, FP);
        for (w = 0; w < 3; w = w + 1) begin
            wr(`TSP_REG_SURF_CTRL, {28'h0, 2'h2, w[1:0]});
            rnd = lfsr(rnd);
            xl(1'b0, 32'h0, {6'h0, rnd[9:0]}, {10'h0, rnd[21:16]}, w != 0,
                FB + tl(w[1:0], FP, {22'h0, rnd[9:0]}, {26'h0, rnd[21:16]}));
        end
        // A frozen clock enable stretches a read.
        fork
            begin
                CLK_EN <= 1'b0;
                repeat (4) @(posedge CORE_CLK);
                CLK_EN <= 1'b1;
            end
            rd(`TSP_REG_SURF_BASE, FB);
        join
        chk(8'h02, FB, FP, 32'h200, 5'h10);
        chk(8'h40, FB, FP, 32'h200, 5'h10);
        chk(8'h41, FB, FP, 32'h200, 5'h00);
        chk(8'h06, FB, FP, 32'h200, 5'h10);
        chk(8'h05, FB, FP, 32'h200, 5'h00);
        chk(8'h0a, FB, FP, 32'h200, 5'h00);
        chk(8'h8e, FB, FP, 32'h200, 5'h10);
        chk(8'h8d, FB, FP, 32'h200, 5'h00);
        chk(8'h09, FB + 32'h100, FP, 32'h200, 5'h01);
        chk(8'h09, FB, 32'h3f0, 32'h100, 5'h02);
        chk(8'h09, FB, 32'h40000, 32'h200, 5'h00);
        chk(8'h09, FB, 32'h40200, 32'h200, 5'h02);
        chk(8'h09, FB, FP, 32'h500, 5'h04);
        chk(8'h19, FB, FP, 32'h200, 5'h00);
        chk(8'h1a, FB, FP, 32'h200, 5'h08);
        chk(8'h19, FB, 32'h800, 32'h200, 5'h02);
        chk(8'h39, FB, 32'h800, 32'h200, 5'h00);
        chk(8'h39, FB, 32'h40000, 32'h200, 5'h02);
        chk(8'h39, FB, 32'h800, 32'h600, 5'h04);
        chk(8'h19, FB + 32'h1000, FP, 32'h200, 5'h01);
        chk(8'h39, 32'h0020_0000, 32'h800, 32'h200, 5'h04);
        chk(8'h39, FB + 32'h1000, 32'h800, 32'h300, 5'h04);
        chk(8'h0b, FB, FP, 32'h200, 5'h10);
        // Sticky status, mask, one-to-clear and a second reset.
        rd(`TSP_REG_STATUS, 32'h1f);
        irq_is(1'b0);
        wr(`TSP_REG_MASK, 32'h08);
        irq_is(1'b1);
        wr(`TSP_REG_STATUS, 32'h08);
        irq_is(1'b0);
        rd(`TSP_REG_STATUS, 32'h17);
        wr(`TSP_REG_MASK, 32'h10);
        irq_is(1'b1);
        @(posedge CORE_CLK);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        irq_is(1'b0);
        rd(`TSP_REG_STATUS, 32'h0);
        repeat (3) @(posedge CORE_CLK);
        cmp("pending", 32'h0, exp_xl.size() + exp_rd.size());
        give_verdict;
    end
endmodule // testbench

// >>> bench/tsp_top_checker.sv
`timescale 1ns/1ps

// Watches bus, translate and interrupt timing at the top ports.
module tsp_top_checker (
    input wire CORE_CLK, // Core clock.
    input wire SYS_RST, // Synchronous reset, active high.
    input wire CLK_EN, // Clock enable.
    input wire AVS_READ, // Bus read request.
    input wire AVS_WRITE, // Bus write request.
    input wire AVS_WAITREQUEST, // Bus wait request.
    input wire IRQ, // Level interrupt.
    input wire XL_REQ, // Translate strobe.
    input wire XL_HOST, // Host or client request.
    input wire [31:0] XL_ADDR, // Host linear address.
    input wire XL_VALID, // Translate answer pulse.
    input wire [31:0] XL_OUT, // Translated address.
    input wire XL_TILED // Tiling applied.
);
    // One clock domain, so clocking and reset are stated once.
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    wire req = AVS_READ || AVS_WRITE;

    property p_wait_idle; !req |-> !AVS_WAITREQUEST; endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest high while idle");
    property p_wait_one; req && AVS_WAITREQUEST && CLK_EN |=> !AVS_WAITREQUEST || !CLK_EN;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("more than one wait cycle");
    property p_wait_two; req && !AVS_WAITREQUEST |=> !req || AVS_WAITREQUEST; endproperty
    a_wait_two: assert property (p_wait_two) else $error("access shorter than two cycles");
    property p_xl_answer; XL_REQ && CLK_EN |=> XL_VALID; endproperty
    a_xl_answer: assert property (p_xl_answer) else $error("translate not answered");
    property p_xl_pulse; !XL_REQ && CLK_EN |=> !XL_VALID; endproperty
    a_xl_pulse: assert property (p_xl_pulse) else $error("translate pulse without request");
    property p_xl_hold; !XL_REQ || !CLK_EN |=> $stable(XL_OUT) && $stable(XL_TILED); endproperty
    a_xl_hold: assert property (p_xl_hold) else $error("translated address moved while idle");
    property p_host_pass; XL_REQ && XL_HOST && CLK_EN |=> XL_TILED || XL_OUT == $past(XL_ADDR);
    endproperty
    a_host_pass: assert property (p_host_pass) else $error("untiled host address altered");
    property p_irq_hold; IRQ && !AVS_WRITE |=> IRQ; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without a write");
    property p_irq_quiet; !IRQ && !AVS_WRITE |=> !IRQ; endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt rose without a write");
endmodule // tsp_top_checker

bind tsp_top tsp_top_checker u_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
    .XL_REQ(XL_REQ), .XL_HOST(XL_HOST), .XL_ADDR(XL_ADDR), .XL_VALID(XL_VALID),
    .XL_OUT(XL_OUT), .XL_TILED(XL_TILED));

// >>> bench/tsp_xl_model.sv
`timescale 1ns/1ps

// Host and internal clients issuing translate requests.
module tsp_xl_model (
    input wire clk, // Core clock.
    output reg req, // Translate strobe.
    output reg host, // High for a host address.
    output reg [31:0] addr, // Host linear address.
    output reg [15:0] x, // Client byte column.
    output reg [15:0] y // Client row.
);
    // Idle at time zero.
    initial begin
        req = 1'b0;
        host = 1'b0;
        addr = 32'h0;
        x = 16'h0;
        y = 16'h0;
    end

    // One request; released lines are inverted so stale values never look valid.
    task automatic send(input logic h, input logic [31:0] a, input logic [15:0] xi,
        input logic [15:0] yi, input integer gap);
        @(posedge clk);
        req <= 1'b1;
        host <= h;
        addr <= a;
        x <= xi;
        y <= yi;
        @(posedge clk);
        req <= 1'b0;
        addr <= ~a;
        x <= ~xi;
        y <= ~yi;
        repeat (gap) @(posedge clk);
    endtask
endmodule // tsp_xl_model

// >>> design/tsp_defs.vh
`ifndef TSP_DEFS_VH
`define TSP_DEFS_VH

// Register word indices on the Avalon address (byte address is four times these).
`define TSP_REG_FENCE_BASE 4'h0
`define TSP_REG_FENCE_CTRL 4'h1
`define TSP_REG_FENCE_END 4'h2
`define TSP_REG_SURF_BASE 4'h3
`define TSP_REG_SURF_PITCH 4'h4
`define TSP_REG_SURF_WIDTH 4'h5
`define TSP_REG_SURF_CTRL 4'h6
`define TSP_REG_CHECK 4'h7
`define TSP_REG_STATUS 4'h8
`define TSP_REG_MASK 4'h9

// Fence control fields.
`define TSP_FC_VALID 0
`define TSP_FC_WALK_LO 1
`define TSP_FC_TILES_LO 8

// Surface control fields.
`define TSP_SC_WALK_LO 0
`define TSP_SC_CLIENT_LO 2
`define TSP_SC_SHARED 4
`define TSP_SC_REMAP 5
`define TSP_SC_ASYNC 6
`define TSP_SC_WIDE 7

// Violation bits, shared by status, mask and check result.
`define TSP_V_ALIGN 0
`define TSP_V_PITCH 1
`define TSP_V_WIDTH 2
`define TSP_V_ORIENT 3
`define TSP_V_FORMAT 4

// Tile walk codes.
`define TSP_WALK_LINEAR 2'h0
`define TSP_WALK_X 2'h1
`define TSP_WALK_Y 2'h2

// Client codes.
`define TSP_CLI_DISPLAY 2'h0
`define TSP_CLI_BLIT 2'h1
`define TSP_CLI_SAMPLER 2'h2
`define TSP_CLI_RENDER 2'h3

// Geometry constants in bytes.
`define TSP_PAGE_BYTES 32'h0000_1000
`define TSP_TILE_X_BYTES 32'h0000_0200
`define TSP_TILE_Y_BYTES 32'h0000_0080
`define TSP_PITCH_MAX_PLAIN 32'h0004_0000
`define TSP_PITCH_MAX_REMAP 32'h0002_0000

// Reset values.
`define TSP_RST_WORD 32'h0000_0000
`define TSP_RST_MASK 5'h00

`endif

// >>> design/tsp_tile_xform.v
`timescale 1ns/1ps
`include "tsp_defs.vh"

// Turns an X (byte column) and Y (row) pair into a byte offset for the given walk.
module tsp_tile_xform (
    input wire [1:0] walk, // Tile walk code.
    input wire [31:0] pitch, // Pitch in bytes.
    input wire [31:0] x, // Byte column within the surface.
    input wire [31:0] y, // Row within the surface.
    output reg [31:0] off // Resulting offset, base not added.
);
    reg [31:0] tile_idx;

    // X tiles are 512 bytes by 8 rows, Y tiles 128 bytes by 32 rows of 16-byte columns.
    always @* begin
        tile_idx = 32'h0;
        case (walk)
            `TSP_WALK_X: begin
                tile_idx = (y >> 3) * (pitch >> 9) + (x >> 9);
                off = {tile_idx[19:0], y[2:0], x[8:0]};
            end
            `TSP_WALK_Y: begin
                tile_idx = (y >> 5) * (pitch >> 7) + (x >> 7);
                off = {tile_idx[19:0], x[6:4], y[4:0], x[3:0]};
            end
            default: begin
                off = y * pitch + x;
            end
        endcase
    end
endmodule // tsp_tile_xform

// >>> design/tsp_top.v
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "tsp_defs.vh"

// Contract
// - Client base untouched; only X/Y offset tiled.
// - Host fenced address tiled whole from fence base.
// - Tile row starts are fence base plus rows.
// - Display rejects Y; async flip needs X.
// - Blit takes linear or X only.
// - Sampler accepts linear, X and Y.
// - Fence tiling masked for internal clients.
module tsp_top #(
    parameter CRD_W = 16 // Width of the client X and Y coordinates.
) (
    input wire CORE_CLK, // Core clock, 25 MHz.
    input wire SYS_RST, // Synchronous reset, active high.
    input wire CLK_EN, // Freezes all state while low.
    input wire [3:0] AVS_ADDRESS, // Register word index.
    input wire AVS_READ, // Avalon read request.
    input wire AVS_WRITE, // Avalon write request.
    input wire [31:0] AVS_WRITEDATA, // Avalon write data.
    input wire [3:0] AVS_BYTEENABLE, // Avalon byte enables.
    output wire [31:0] AVS_READDATA, // Avalon read data.
    output wire AVS_WAITREQUEST, // Avalon wait request.
    output wire IRQ, // Level interrupt, unmasked violation pending.
    input wire XL_REQ, // Translate request strobe.
    input wire XL_HOST, // High for a host linear address, low for a client X/Y.
    input wire [31:0] XL_ADDR, // Host linear address.
    input wire [CRD_W-1:0] XL_X, // Client byte column.
    input wire [CRD_W-1:0] XL_Y, // Client row.
    output wire XL_VALID, // One-cycle pulse with the translated address.
    output wire [31:0] XL_OUT, // Translated address.
    output wire XL_TILED // Translated address went through tiling.
);
    reg [31:0] fence_base_q;
    reg [31:0] fence_end_q;
    reg fence_valid_q;
    reg [1:0] fence_walk_q;
    reg [10:0] fence_tiles_q;
    reg [31:0] surf_base_q;
    reg [18:0] surf_pitch_q;
    reg [18:0] surf_width_q;
    reg [7:0] surf_ctrl_q;
    reg [4:0] status_q;
    reg [4:0] status_d;
    reg [4:0] mask_q;
    reg ack_q;
    reg [31:0] rdata_q;
    reg xl_valid_q;
    reg [31:0] xl_out_q;
    reg xl_tiled_q;
    reg [31:0] rd_mux;
    reg [4:0] viol;

    // Merges write data into a register under the byte enables.
    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer i;
        begin
            be_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    be_merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // Tile width in bytes for a walk; a linear walk counts as one byte.
    function [31:0] tile_width;
        input [1:0] walk;
        begin
            case (walk)
                `TSP_WALK_X: tile_width = `TSP_TILE_X_BYTES;
                `TSP_WALK_Y: tile_width = `TSP_TILE_Y_BYTES;
                default: tile_width = 32'h1;
            endcase
        end
    endfunction

    // Guards a divisor against zero so an unprogrammed fence gives no unknowns.
    function [31:0] safe_div;
        input [31:0] d;
        begin
            safe_div = (d == 32'h0) ? 32'h1 : d;
        end
    endfunction

    // Avalon handshake: one wait cycle, then the access completes.
    wire req = AVS_READ | AVS_WRITE;
    wire done = req & ack_q & CLK_EN;
    wire wr_go = AVS_WRITE & done;
    assign AVS_WAITREQUEST = req & ~(ack_q & CLK_EN);
    assign AVS_READDATA = rdata_q;

    // Surface control fields.
    wire [1:0] surf_walk = surf_ctrl_q[`TSP_SC_WALK_LO +: 2];
    wire [1:0] client = surf_ctrl_q[`TSP_SC_CLIENT_LO +: 2];
    wire shared = surf_ctrl_q[`TSP_SC_SHARED];
    wire remap = surf_ctrl_q[`TSP_SC_REMAP];
    wire async_flip = surf_ctrl_q[`TSP_SC_ASYNC];
    wire wide_fmt = surf_ctrl_q[`TSP_SC_WIDE];

    // Fence geometry: pitch in bytes and the size of one tile row in memory.
    wire [31:0] fence_pitch_b = {21'h0, fence_tiles_q} * tile_width(fence_walk_q);
    wire [31:0] row_size = {9'h0, fence_tiles_q, 12'h0};
    wire [31:0] surf_pitch_b = {13'h0, surf_pitch_q};
    wire [31:0] surf_width_b = {13'h0, surf_width_q};
    // Merged pitch and width words; only the low 19 bits are stored.
    wire [31:0] pitch_wr = be_merge(surf_pitch_b, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] width_wr = be_merge(surf_width_b, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] tw_surf = tile_width(surf_walk);
    wire surf_tiled = (surf_walk != `TSP_WALK_LINEAR);

    // Where the surface base lands in the fence: row start check and column.
    wire [31:0] base_rel = surf_base_q - fence_base_q;
    wire [31:0] base_in_row = base_rel % safe_div(row_size);
    wire [31:0] base_col = (base_in_row >> 12) * tile_width(fence_walk_q);
    wire base_in_fence = fence_valid_q & (surf_base_q >= fence_base_q)
        & (surf_base_q < fence_end_q);
    wire is_row_start = base_in_fence & (base_in_row == 32'h0);
    wire [31:0] pitch_lim = (shared & remap) ? `TSP_PITCH_MAX_REMAP
        : `TSP_PITCH_MAX_PLAIN;
    wire fence_pitch_bad = (fence_tiles_q == 11'h0)
        | (fence_pitch_b > `TSP_PITCH_MAX_REMAP);

    // Placement checks; each feeds one violation bit.
    always @* begin
        viol = 5'h0;
        // Descriptor base of a tiled surface must sit on a page.
        viol[`TSP_V_ALIGN] = surf_tiled & (surf_base_q[11:0] != 12'h0);
        if (shared & ~remap) begin
            viol[`TSP_V_ALIGN] = viol[`TSP_V_ALIGN] | ~is_row_start;
        end
        // Pitch: tile multiple and ceiling, plus the fence pairing when shared.
        viol[`TSP_V_PITCH] = surf_tiled & (((surf_pitch_b & (tw_surf - 32'h1)) != 32'h0)
            | (surf_pitch_b > pitch_lim));
        if (shared) begin
            viol[`TSP_V_PITCH] = viol[`TSP_V_PITCH] | fence_pitch_bad
                | (~remap & (surf_pitch_b != fence_pitch_b));
        end
        // Width against the surface pitch, and against the fence pitch and the right fence edge for shared surfaces.
        viol[`TSP_V_WIDTH] = (surf_width_b > surf_pitch_b);
        if (shared) begin
            viol[`TSP_V_WIDTH] = viol[`TSP_V_WIDTH] | (surf_width_b > fence_pitch_b)
                | (base_col + surf_width_b > fence_pitch_b) | ~base_in_fence;
        end
        // Fence and surface must walk the same way.
        viol[`TSP_V_ORIENT] = shared & (~fence_valid_q
            | (fence_walk_q != surf_walk));
        // Per-client format support.
        case (client)
            `TSP_CLI_DISPLAY: viol[`TSP_V_FORMAT] = (surf_walk == `TSP_WALK_Y)
                | (async_flip & (surf_walk != `TSP_WALK_X));
            `TSP_CLI_BLIT: viol[`TSP_V_FORMAT] = (surf_walk == `TSP_WALK_Y);
            `TSP_CLI_SAMPLER: viol[`TSP_V_FORMAT] = 1'b0;
            `TSP_CLI_RENDER: viol[`TSP_V_FORMAT] = wide_fmt
                & (surf_walk == `TSP_WALK_Y);
            default: viol[`TSP_V_FORMAT] = 1'b0;
        endcase
        if (surf_walk == 2'h3) begin
            viol[`TSP_V_FORMAT] = 1'b1;
        end
    end

    // Host side: only a valid fence claims an address; the rest stays linear.
    wire host_in_fence = fence_valid_q & (XL_ADDR >= fence_base_q)
        & (XL_ADDR < fence_end_q) & (fence_walk_q != `TSP_WALK_LINEAR);
    wire [31:0] host_off = XL_ADDR - fence_base_q;
    wire [31:0] host_y = host_off / safe_div(fence_pitch_b);
    wire [31:0] host_x = host_off % safe_div(fence_pitch_b);

    // One transform serves both paths; clients never see the fence.
    wire use_fence = XL_HOST & host_in_fence;
    wire [1:0] xf_walk = use_fence ? fence_walk_q : surf_walk;
    wire [31:0] xf_pitch = use_fence ? fence_pitch_b : surf_pitch_b;
    wire [31:0] xf_x = use_fence ? host_x : {{(32-CRD_W){1'b0}}, XL_X};
    wire [31:0] xf_y = use_fence ? host_y : {{(32-CRD_W){1'b0}}, XL_Y};
    wire [31:0] xf_off;

    tsp_tile_xform u_xform (
        .walk(xf_walk),
        .pitch(xf_pitch),
        .x(xf_x),
        .y(xf_y),
        .off(xf_off)
    );

    assign XL_VALID = xl_valid_q;
    assign XL_OUT = xl_out_q;
    assign XL_TILED = xl_tiled_q;

    // Read multiplexer; unmapped words read as zero.
    always @* begin
        case (AVS_ADDRESS)
            `TSP_REG_FENCE_BASE: rd_mux = fence_base_q;
            `TSP_REG_FENCE_CTRL: rd_mux = {13'h0, fence_tiles_q, 5'h0,
                fence_walk_q, fence_valid_q};
            `TSP_REG_FENCE_END: rd_mux = fence_end_q;
            `TSP_REG_SURF_BASE: rd_mux = surf_base_q;
            `TSP_REG_SURF_PITCH: rd_mux = surf_pitch_b;
            `TSP_REG_SURF_WIDTH: rd_mux = surf_width_b;
            `TSP_REG_SURF_CTRL: rd_mux = {24'h0, surf_ctrl_q};
            `TSP_REG_CHECK: rd_mux = {27'h0, viol};
            `TSP_REG_STATUS: rd_mux = {27'h0, status_q};
            `TSP_REG_MASK: rd_mux = {27'h0, mask_q};
            default: rd_mux = 32'h0;
        endcase
    end

    // Sticky status: a check sets, a one written clears, and a set in the same
    // cycle as its clear wins so no violation is ever lost.
    wire chk_go = wr_go & (AVS_ADDRESS == `TSP_REG_CHECK) & AVS_BYTEENABLE[0]
        & AVS_WRITEDATA[0];
    wire [4:0] st_clr = (wr_go & (AVS_ADDRESS == `TSP_REG_STATUS)
        & AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[4:0] : 5'h0;
    always @* begin
        status_d = (status_q & ~st_clr) | (chk_go ? viol : 5'h0);
    end
    assign IRQ = |(status_q & mask_q);

    // Register file and bus state; writes land at the edge that ends the wait.
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            fence_base_q <= `TSP_RST_WORD;
            fence_end_q <= `TSP_RST_WORD;
            fence_valid_q <= 1'b0;
            fence_walk_q <= `TSP_WALK_LINEAR;
            fence_tiles_q <= 11'h0;
            surf_base_q <= `TSP_RST_WORD;
            surf_pitch_q <= 19'h0;
            surf_width_q <= 19'h0;
            surf_ctrl_q <= 8'h0;
            status_q <= 5'h0;
            mask_q <= `TSP_RST_MASK;
            ack_q <= 1'b0;
            rdata_q <= `TSP_RST_WORD;
        end else if (CLK_EN) begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q) begin
                rdata_q <= rd_mux;
            end
            status_q <= status_d;
            if (wr_go) begin
                case (AVS_ADDRESS)
                    `TSP_REG_FENCE_BASE: begin
                        fence_base_q <= be_merge(fence_base_q, AVS_WRITEDATA,
                            AVS_BYTEENABLE) & 32'hffff_f000;
                    end
                    `TSP_REG_FENCE_CTRL: begin
                        if (AVS_BYTEENABLE[0]) begin
                            fence_valid_q <= AVS_WRITEDATA[`TSP_FC_VALID];
                            fence_walk_q <= AVS_WRITEDATA[`TSP_FC_WALK_LO +: 2];
                        end
                        if (AVS_BYTEENABLE[1] & AVS_BYTEENABLE[2]) begin
                            fence_tiles_q <= AVS_WRITEDATA[`TSP_FC_TILES_LO +: 11];
                        end
                    end
                    `TSP_REG_FENCE_END: begin
                        fence_end_q <= be_merge(fence_end_q, AVS_WRITEDATA,
                            AVS_BYTEENABLE) & 32'hffff_f000;
                    end
                    `TSP_REG_SURF_BASE: begin
                        surf_base_q <= be_merge(surf_base_q, AVS_WRITEDATA,
                            AVS_BYTEENABLE);
                    end
                    `TSP_REG_SURF_PITCH: begin
                        surf_pitch_q <= pitch_wr[18:0];
                    end
                    `TSP_REG_SURF_WIDTH: begin
                        surf_width_q <= width_wr[18:0];
                    end
                    `TSP_REG_SURF_CTRL: begin
                        if (AVS_BYTEENABLE[0]) begin
                            surf_ctrl_q <= AVS_WRITEDATA[7:0];
                        end
                    end
                    `TSP_REG_MASK: begin
                        if (AVS_BYTEENABLE[0]) begin
                            mask_q <= AVS_WRITEDATA[4:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Translation result, one cycle after the request; the client base is added
    // as is, so it never passes through the tile transform.
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            xl_valid_q <= 1'b0;
            xl_out_q <= `TSP_RST_WORD;
            xl_tiled_q <= 1'b0;
        end else if (CLK_EN) begin
            xl_valid_q <= XL_REQ;
            if (XL_REQ) begin
                if (XL_HOST) begin
                    xl_out_q <= use_fence ? fence_base_q + xf_off : XL_ADDR;
                    xl_tiled_q <= use_fence;
                end else begin
                    xl_out_q <= surf_base_q + xf_off;
                    xl_tiled_q <= surf_tiled;
                end
            end
        end
    end
endmodule // tsp_top
